// *** design/sfw_cfg.svh ***
`ifndef SFW_CFG_SVH
`define SFW_CFG_SVH
// fifo geometry defaults
`define SFW_DATA_W      8
`define SFW_DEPTH       16
`define SFW_NUM_FIFO    4
`define SFW_SEL_W       2
// strobe timing (ns) and clock period (ns)
`define SFW_CLK_NS      40
`define SFW_WR_HIGH_NS  70
`define SFW_CYC_UP(ns)  (((ns) + `SFW_CLK_NS - 1) / `SFW_CLK_NS)
`endif

// *** design/sfw_pkg.sv ***
package sfw_pkg;
  typedef enum logic [1:0] {
    SFW_IDLE,
    SFW_WR_LOW,
    SFW_PE_LOW
  } sfw_state_t;
endpackage

// *** design/sfw_sync.sv ***
`timescale 1ns/1ns
// two-flop synchroniser for a bundle of async levels
module sfw_sync #(
  parameter int W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfw_sync_st_t;

  sfw_sync_st_t st_r;
  sfw_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {RST, RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// *** design/sfw_top.sv ***
`timescale 1ns/1ns
`include "sfw_cfg.svh"
module sfw_top #(
  parameter int DATA_W   = `SFW_DATA_W,
  parameter int DEPTH    = `SFW_DEPTH,
  parameter int NUM_FIFO = `SFW_NUM_FIFO,
  parameter int SEL_W    = `SFW_SEL_W
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // external master pins (active low strobes)
  input  wire logic                      fifo_write_strobe_n,
  input  wire logic                      packet_commit_strobe_n,
  input  wire logic                      port_chip_select_n,
  input  wire logic [SEL_W-1:0]          fifo_select_bits,
  input  wire logic [DATA_W-1:0]         fifo_data,
  // flags of the selected fifo
  output logic                           fifo_full,
  output logic                           fifo_empty,
  // drain side: host takes committed packets
  output logic                           pkt_valid,
  output logic [SEL_W-1:0]               pkt_fifo,
  output logic [$clog2(DEPTH+1)-1:0]     pkt_len,
  input  wire logic                      pkt_taken,
  // per-fifo byte read port for the host engine
  input  wire logic [SEL_W-1:0]          rd_fifo,
  input  wire logic [$clog2(DEPTH)-1:0]  rd_idx,
  output logic [DATA_W-1:0]              rd_data,
  // misuse seen on the pins
  output logic                           strobe_clash
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = DATA_W + SEL_W;

  // -------------------------------------------------------------
  // reset release and pin synchronisers
  // -------------------------------------------------------------
  logic [1:0] rst_sh_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sh_r <= 2'h0;
    end else begin
      rst_sh_r <= {rst_sh_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sh_r[1];

  logic       wr_s;
  logic       pe_s;
  logic       cs_s;
  logic [2:0] strb_q;

  // active-high internal copies, synchronised before any edge logic
  sfw_sync #(.W(3), .RST(3'h0)) u_sync_strb (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({~fifo_write_strobe_n, ~packet_commit_strobe_n, ~port_chip_select_n}),
    .q     (strb_q)
  );
  assign wr_s = strb_q[2];
  assign pe_s = strb_q[1];
  assign cs_s = strb_q[0];

  // data and select follow the same two-flop path so they align with the strobe edge
  logic [PW-1:0] bus_q;
  sfw_sync #(.W(PW), .RST('0)) u_sync_bus (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({fifo_select_bits, fifo_data}),
    .q     (bus_q)
  );

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    sfw_pkg::sfw_state_t            st;
    logic [NUM_FIFO-1:0][AW-1:0]    wptr;
    logic [NUM_FIFO-1:0][CW-1:0]    cnt;
    logic [NUM_FIFO-1:0][DEPTH-1:0][DATA_W-1:0] mem;
    logic [PW-1:0]                  bus_hold;
    logic                           full;
    logic                           empty;
    logic                           pvalid;
    logic [SEL_W-1:0]               pfifo;
    logic [CW-1:0]                  plen;
    logic [DATA_W-1:0]              rdata;
    logic                           clash;
  } sfw_st_t;

  sfw_st_t s_r;
  sfw_st_t s_nxt;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  logic [SEL_W-1:0] sel_now;
  logic [SEL_W-1:0] sel_hold;
  assign sel_now  = bus_q[PW-1:DATA_W];
  assign sel_hold = s_r.bus_hold[PW-1:DATA_W];

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.clash = wr_s & pe_s;
    if (pkt_taken && s_r.pvalid) begin
      s_nxt.pvalid = 1'b0;
      s_nxt.cnt[s_r.pfifo] = '0;
    end
    unique case (s_r.st)
      sfw_pkg::SFW_IDLE: begin
        if (wr_s && cs_s && !pe_s) begin
          s_nxt.st = sfw_pkg::SFW_WR_LOW;
        end else if (pe_s && cs_s && !wr_s) begin
          s_nxt.st       = sfw_pkg::SFW_PE_LOW;
          s_nxt.bus_hold = bus_q;
        end
      end
      sfw_pkg::SFW_WR_LOW: begin
        // keep latest bus sample; the byte is whatever stood before the release
        s_nxt.bus_hold = bus_q;
        if (!wr_s) begin
          s_nxt.st = sfw_pkg::SFW_IDLE;
          // store first, then post-increment; full fifo drops the byte
          if (s_r.cnt[sel_hold] != CW'(DEPTH)) begin
            s_nxt.mem[sel_hold][s_r.wptr[sel_hold]] = s_r.bus_hold[DATA_W-1:0];
            s_nxt.wptr[sel_hold] = ptr_inc(s_r.wptr[sel_hold]);
            s_nxt.cnt[sel_hold]  = CW'(s_nxt.cnt[sel_hold] + 1'b1);
          end
        end
      end
      sfw_pkg::SFW_PE_LOW: begin
        if (!pe_s) begin
          s_nxt.st = sfw_pkg::SFW_IDLE;
          // one packet in flight; a commit while one is still held is dropped
          if (!s_nxt.pvalid && s_r.cnt[sel_hold] != '0) begin
            s_nxt.pvalid = 1'b1;
            s_nxt.pfifo  = sel_hold;
            s_nxt.plen   = s_r.cnt[sel_hold];
          end
        end
      end
      default: s_nxt.st = sfw_pkg::SFW_IDLE;
    endcase
    // flags come from the next counts, so they move on the same edge as the count
    s_nxt.full  = (s_nxt.cnt[sel_now] == CW'(DEPTH));
    s_nxt.empty = (s_nxt.cnt[sel_now] == '0);
    s_nxt.rdata = s_r.mem[rd_fifo][rd_idx];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.st    <= sfw_pkg::SFW_IDLE;
      s_r.empty <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fifo_full    = s_r.full;
  assign fifo_empty   = s_r.empty;
  assign pkt_valid    = s_r.pvalid;
  assign pkt_fifo     = s_r.pfifo;
  assign pkt_len      = s_r.plen;
  assign rd_data      = s_r.rdata;
  assign strobe_clash = s_r.clash;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  logic [SEL_W-1:0] h_sel;
  assign h_sel = sel_hold;

  property p_wr_store;
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == sfw_pkg::SFW_WR_LOW && !wr_s && s_r.cnt[h_sel] != CW'(DEPTH))
      |=> (s_r.wptr[$past(h_sel)] == ptr_inc($past(s_r.wptr[h_sel])));
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("pointer did not advance after write");

  property p_wr_data;
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == sfw_pkg::SFW_WR_LOW && !wr_s && s_r.cnt[h_sel] != CW'(DEPTH))
      |=> (s_r.mem[$past(h_sel)][$past(s_r.wptr[h_sel])] == $past(s_r.bus_hold[DATA_W-1:0]));
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("written byte not stored");

  property p_flag;
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == sfw_pkg::SFW_WR_LOW && !wr_s && $stable(sel_now) && sel_now == h_sel)
      |-> ##[1:2] !fifo_empty;
  endproperty
  a_flag: assert property (p_flag) else $error("empty flag stayed after write");

  property p_commit;
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == sfw_pkg::SFW_PE_LOW && !pe_s && !s_r.pvalid && s_r.cnt[h_sel] != '0)
      |=> pkt_valid && pkt_len == $past(s_r.cnt[h_sel]);
  endproperty
  a_commit: assert property (p_commit) else $error("packet end did not commit");

  property p_cs;
    @(posedge clk) disable iff (!rst_n)
    (s_r.st == sfw_pkg::SFW_IDLE && wr_s && !cs_s) |=> s_r.st == sfw_pkg::SFW_IDLE;
  endproperty
  a_cs: assert property (p_cs) else $error("write started without chip select");

  property p_clash;
    @(posedge clk) disable iff (!rst_n)
    (wr_s && pe_s) |=> strobe_clash;
  endproperty
  a_clash: assert property (p_clash) else $error("strobe overlap not flagged");
endmodule

// *** verification/sfw_master.sv ***
`timescale 1ns/1ns
// behavioural external master on the async write pins
module sfw_master (
  // clock used only to pace the pins
  input  wire logic       clk,
  // pins toward the device
  output logic            wr_n,
  output logic            pe_n,
  output logic            cs_n,
  output logic [1:0]      sel,
  output logic [7:0]      data
);
  initial begin
    wr_n = 1'b1;
    pe_n = 1'b1;
    cs_n = 1'b1;
    sel  = 2'h0;
    data = 8'h00;
  end

  // one byte; data flips on release so a late sample is caught
  task automatic put(input logic [1:0] s, input logic [7:0] b);
    @(negedge clk);
    cs_n <= 1'b0;
    sel  <= s;
    data <= b;
    @(negedge clk);
    wr_n <= 1'b0;
    repeat (3) @(negedge clk);
    wr_n <= 1'b1;
    data <= ~b;
    repeat (5) @(negedge clk);
  endtask

  // write pulse with chip select released; the device must ignore it
  task automatic put_nocs(input logic [1:0] s, input logic [7:0] b);
    @(negedge clk);
    cs_n <= 1'b1;
    sel  <= s;
    data <= b;
    @(negedge clk);
    wr_n <= 1'b0;
    repeat (3) @(negedge clk);
    wr_n <= 1'b1;
    repeat (5) @(negedge clk);
    cs_n <= 1'b0;
  endtask

  // both strobes together, deliberately against the rules, to provoke the misuse flag
  task automatic overlap(input logic on);
    @(negedge clk);
    wr_n <= ~on;
    pe_n <= ~on;
    repeat (4) @(negedge clk);
  endtask

  // select held for the whole low phase
  task automatic commit(input logic [1:0] s);
    @(negedge clk);
    sel  <= s;
    pe_n <= 1'b0;
    repeat (3) @(negedge clk);
    pe_n <= 1'b1;
    repeat (5) @(negedge clk);
  endtask
endmodule

// *** verification/async_slave_fifo_write_bench.sv ***
`timescale 1ns/1ns
module async_slave_fifo_write_bench;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       wr_n, pe_n, cs_n, full, empty, pv, clash;
  logic [1:0] sel, pf;
  logic [7:0] data, rd_data;
  logic [4:0] plen;
  logic       pkt_taken = 1'b0;
  logic [1:0] rd_fifo = 2'h0;
  logic [3:0] rd_idx = 4'h0;
  int         n_errors = 0;
  int         cmp_count = 0;

  always #20 clk = ~clk;

  sfw_master m (.clk(clk), .wr_n(wr_n), .pe_n(pe_n), .cs_n(cs_n), .sel(sel), .data(data));

  sfw_top i_dut (.clk(clk), .arst_n(arst_n), .fifo_write_strobe_n(wr_n), .packet_commit_strobe_n(pe_n),
    .port_chip_select_n(cs_n), .fifo_select_bits(sel), .fifo_data(data), .fifo_full(full),
    .fifo_empty(empty), .pkt_valid(pv), .pkt_fifo(pf), .pkt_len(plen), .pkt_taken(pkt_taken),
    .rd_fifo(rd_fifo), .rd_idx(rd_idx), .rd_data(rd_data), .strobe_clash(clash));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [1:0] f, input logic [3:0] i, input logic [7:0] e);
    rd_fifo <= f;
    rd_idx  <= i;
    repeat (2) @(negedge clk);
    check(rd_data, e);
  endtask

  task automatic take();
    pkt_taken <= 1'b1;
    @(negedge clk);
    pkt_taken <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({7'h0, empty}, 8'h01);
    check({7'h0, full}, 8'h00);
    m.commit(2'h3);
    check({7'h0, pv}, 8'h00);
  endtask

  // single write then burst of three, committed as a short packet
  task automatic t_short();
    m.put(2'h1, 8'ha0);
    check({7'h0, empty}, 8'h00);
    for (int k = 1; k < 4; k++) begin
      m.put(2'h1, 8'ha0 + 8'(k));
    end
    check({7'h0, clash}, 8'h00);
    m.commit(2'h1);
    check({7'h0, pv}, 8'h01);
    check({6'h0, pf}, 8'h01);
    check({3'h0, plen}, 8'h04);
    for (int k = 0; k < 4; k++) begin
      rd_chk(2'h1, 4'(k), 8'ha0 + 8'(k));
    end
    take();
    check({7'h0, pv}, 8'h00);
    check({7'h0, empty}, 8'h01);
  endtask

  // fill to the top; one extra byte must be dropped
  task automatic t_full();
    for (int k = 0; k < 16; k++) begin
      m.put(2'h2, 8'h40 + 8'(k));
    end
    check({7'h0, full}, 8'h01);
    m.put(2'h2, 8'hee);
    m.commit(2'h2);
    check({3'h0, plen}, 8'h10);
    rd_chk(2'h2, 4'h0, 8'h40);
    rd_chk(2'h2, 4'hf, 8'h4f);
    take();
  endtask

  // misuse on the pins: write without chip select, then both strobes at once
  task automatic t_misuse();
    m.put_nocs(2'h0, 8'h5a);
    check({7'h0, empty}, 8'h01);
    m.overlap(1'b1);
    check({7'h0, clash}, 8'h01);
    m.overlap(1'b0);
    check({7'h0, clash}, 8'h00);
    check({7'h0, empty}, 8'h01);
    check({7'h0, pv}, 8'h00);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    arst_n <= 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_short();
    t_full();
    t_misuse();
    summarize();
  end

  // about 300 cycles expected; generous margin
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
